// ---- pbh_bus.sv ----
// Primary external bus engine with release handshake and float control
`timescale 1ns/1ps
`default_nettype none
`include "pbh_map.svh"

module pbh_bus
	import pbh_pkg::*;
#(
	parameter int ADDR_W = `PBH_ADDR_W,
	parameter int DATA_W = `PBH_DATA_W,
	parameter logic [`PBH_ADDR_W-1:0] RESET_VECTOR = `PBH_RESET_VECTOR
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_req_valid,
	input wire logic i_req_read,
	input wire logic [ADDR_W-1:0] i_req_addr,
	input wire logic [DATA_W-1:0] i_req_wdata,
	output logic o_req_ready,
	output logic o_rsp_valid,
	output logic [DATA_W-1:0] o_rsp_rdata,
	output logic [ADDR_W-1:0] o_start_addr,
	input wire logic i_ignore_release_req,
	input wire logic i_shutdown_float_n,
	input wire logic i_release_req_n,
	input wire logic i_ready_n,
	output logic [ADDR_W-1:0] o_addr_bus,
	output logic o_addr_oe,
	input wire logic [DATA_W-1:0] i_data_bus,
	output logic [DATA_W-1:0] o_data_bus,
	output logic o_data_oe,
	output logic o_read_write,
	output logic o_rw_oe,
	output logic o_access_strobe_n,
	output logic o_strobe_oe,
	output logic [`PBH_PAGE_N-1:0] o_page_select_n,
	output logic o_page_oe,
	output logic o_bus_release_ack_n,
	output logic o_ack_oe
);
	pbh_state_type state, next_state;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [DATA_W-1:0] wdata, next_wdata;
	logic [DATA_W-1:0] keep, next_keep;
	logic [DATA_W-1:0] rdata, next_rdata;
	logic rd, next_rd;
	logic rsp, next_rsp;
	logic strobe_n, next_strobe_n;
	logic release_req;
	logic in_reset;

	// Page strobe decoded from the top address bits, active low
	function automatic logic [`PBH_PAGE_N-1:0] page_dec(
		input logic [ADDR_W-1:0] a);
		logic [`PBH_PAGE_N-1:0] p;
		p = {`PBH_PAGE_N{1'b1}};
		p[a[`PBH_PAGE_LSB +: 2]] = 1'b0;
		return p;
	endfunction

	assign release_req = !i_release_req_n && !i_ignore_release_req;
	assign in_reset = !i_nrst;

	assign o_start_addr = RESET_VECTOR;
	assign o_req_ready = (state == PBH_IDLE) && !release_req && i_nrst;

	// Bus sequencing: access, hold and tail of the acknowledge
	always_comb begin
		next_state = state;
		next_addr = addr;
		next_wdata = wdata;
		next_rd = rd;
		next_rsp = 1'b0;
		next_rdata = rdata;
		next_strobe_n = 1'b1;
		next_keep = keep;
		case (state)
			PBH_IDLE: begin
				if (release_req) begin
					next_state = PBH_HELD;
				end else if (i_req_valid) begin
					next_state = PBH_ACCESS;
					next_addr = i_req_addr;
					next_wdata = i_req_wdata;
					next_rd = i_req_read;
					next_strobe_n = 1'b0;
				end
			end
			PBH_ACCESS: begin
				if (!i_ready_n) begin
					next_rsp = 1'b1;
					if (rd) begin
						next_rdata = i_data_bus;
					end else begin
						next_keep = wdata;
					end
					next_state = release_req ? PBH_HELD : PBH_IDLE;
				end else begin
					next_strobe_n = 1'b0;
				end
			end
			PBH_HELD: begin
				// leave hold, ack lingers a cycle unless ignored
				if (i_ignore_release_req) begin
					next_state = PBH_IDLE;
				end else if (i_release_req_n) begin
					next_state = PBH_TAIL;
				end
			end
			PBH_TAIL: begin
				next_state = PBH_IDLE;
			end
			default: begin
				next_state = PBH_IDLE;
			end
		endcase
	end

	// Register the sequencer; data keeper survives reset like a bus keeper
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state <= PBH_IDLE;
			addr <= RESET_VECTOR;
			wdata <= '0;
			rd <= 1'b1;
			rsp <= 1'b0;
			rdata <= '0;
			strobe_n <= 1'b1;
		end else begin
			state <= next_state;
			addr <= next_addr;
			wdata <= next_wdata;
			rd <= next_rd;
			rsp <= next_rsp;
			rdata <= next_rdata;
			strobe_n <= next_strobe_n;
		end
		keep <= next_keep;
	end

	// keeper: idle write data stays on the port value last driven
	assign o_data_bus = (state == PBH_ACCESS) ? wdata : keep;
	assign o_rsp_valid = rsp;
	assign o_rsp_rdata = rdata;
	assign o_addr_bus = addr;
	assign o_read_write = rd;
	assign o_access_strobe_n = strobe_n;
	assign o_page_select_n = strobe_n ? {`PBH_PAGE_N{1'b1}} : page_dec(addr);

	always_comb begin
		logic held;
		held = (state == PBH_HELD) || (state == PBH_TAIL);
		o_addr_oe = i_shutdown_float_n && !held && !in_reset;
		o_rw_oe = o_addr_oe;
		o_page_oe = o_addr_oe;
		o_data_oe = o_addr_oe && (state == PBH_ACCESS) && !rd;
		o_strobe_oe = i_shutdown_float_n && !held;
		o_ack_oe = i_shutdown_float_n;
	end

	assign o_bus_release_ack_n = !((state == PBH_HELD) || (state == PBH_TAIL));

	ack_float_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!o_bus_release_ack_n |-> !o_addr_oe && !o_strobe_oe && !o_data_oe)
		else $error("ack low while bus driven");
	ignore_ack_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ignore_release_req |=> o_bus_release_ack_n)
		else $error("ack low while ignore set");
	sequence rel_rise_s;
		!o_bus_release_ack_n && i_release_req_n && !i_ignore_release_req;
	endsequence
	ack_tail_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(rel_rise_s and (state == PBH_HELD)) |=> !o_bus_release_ack_n
		##1 o_bus_release_ack_n)
		else $error("ack tail not one cycle");
	hold_entry_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(!i_release_req_n && !i_ignore_release_req && state == PBH_IDLE)
		|=> !o_bus_release_ack_n)
		else $error("idle release not acknowledged");
	wait_state_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state == PBH_ACCESS && i_ready_n |=> !o_access_strobe_n)
		else $error("strobe dropped before ready");
	page_strobe_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!o_access_strobe_n |-> $onehot(~o_page_select_n))
		else $error("page strobe not one-hot");
	dir_follow_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_req_ready && i_req_valid |=> o_read_write == $past(i_req_read))
		else $error("direction wrong");
	shutdown_float_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_shutdown_float_n |-> !o_addr_oe && !o_strobe_oe && !o_ack_oe)
		else $error("output driven under shutdown");
	reset_float_a: assert property (@(posedge i_clk)
		!i_nrst && i_shutdown_float_n && state == PBH_IDLE
		|-> !o_addr_oe && o_strobe_oe)
		else $error("reset float wrong");
endmodule // pbh_bus
`default_nettype wire

// ---- pbh_map.svh ----
// Constants for the primary bus hold interface
`ifndef PBH_MAP_SVH
`define PBH_MAP_SVH
`define PBH_ADDR_W 24
`define PBH_DATA_W 32
`define PBH_PAGE_N 4
`define PBH_PAGE_LSB 22
`define PBH_RESET_VECTOR 24'h00_0000
`define PBH_ACK_HOLD_CYC 1
`endif

// ---- pbh_mem.sv ----
// External memory that answers bus accesses after set waits
`timescale 1ns/1ps
`default_nettype none
module pbh_mem (
	input wire logic i_clk,
	input wire logic i_strobe_n,
	input wire logic i_rw,
	input wire logic [23:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wait,
	output logic o_ready_n,
	output logic [31:0] o_rdata,
	output logic o_rd_oe
);
	logic [31:0] mem [16];
	logic [3:0] cnt = 4'h0;
	// ready low once waits are spent
	assign o_ready_n = i_strobe_n || cnt < i_wait;
	assign o_rd_oe = !i_strobe_n && i_rw;
	assign o_rdata = mem[i_addr[3:0]];
	// Write lands on the completing cycle
	always @(posedge i_clk) begin
		cnt <= i_strobe_n ? 4'h0 : cnt + 4'h1;
		if (!o_ready_n && !i_rw)
			mem[i_addr[3:0]] <= i_wdata;
	end
endmodule // pbh_mem
`default_nettype wire

// ---- pbh_pkg.sv ----
// Types for the primary bus hold interface
`default_nettype none
package pbh_pkg;
	typedef enum logic [3:0] {
		PBH_IDLE = 4'b0001,
		PBH_ACCESS = 4'b0010,
		PBH_HELD = 4'b0100,
		PBH_TAIL = 4'b1000
	} pbh_state_type;
endpackage
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the bus hold interface
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_clk = 0, i_nrst = 0, i_req_valid = 0, i_req_read = 0;
	logic i_ignore_release_req = 0, i_shutdown_float_n = 1;
	logic i_release_req_n = 1, i_ready_n, rd_oe;
	logic [23:0] i_req_addr = 0, o_start_addr, o_addr_bus;
	logic [31:0] i_req_wdata = 0, i_data_bus, kp = 0;
	logic [31:0] o_rsp_rdata, o_data_bus, rdat;
	logic [3:0] wt = 0, o_page_select_n;
	logic o_req_ready, o_rsp_valid, o_addr_oe, o_data_oe;
	logic o_read_write, o_rw_oe, o_access_strobe_n, o_strobe_oe;
	logic o_page_oe, o_bus_release_ack_n, o_ack_oe;
	int n_fail = 0, checks = 0, cyc = 0;
	pbh_bus DUT (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_req_valid(i_req_valid),
		.i_req_read(i_req_read),
		.i_req_addr(i_req_addr),
		.i_req_wdata(i_req_wdata),
		.o_req_ready(o_req_ready),
		.o_rsp_valid(o_rsp_valid),
		.o_rsp_rdata(o_rsp_rdata),
		.o_start_addr(o_start_addr),
		.i_ignore_release_req(i_ignore_release_req),
		.i_shutdown_float_n(i_shutdown_float_n),
		.i_release_req_n(i_release_req_n),
		.i_ready_n(i_ready_n),
		.o_addr_bus(o_addr_bus),
		.o_addr_oe(o_addr_oe),
		.i_data_bus(i_data_bus),
		.o_data_bus(o_data_bus),
		.o_data_oe(o_data_oe),
		.o_read_write(o_read_write),
		.o_rw_oe(o_rw_oe),
		.o_access_strobe_n(o_access_strobe_n),
		.o_strobe_oe(o_strobe_oe),
		.o_page_select_n(o_page_select_n),
		.o_page_oe(o_page_oe),
		.o_bus_release_ack_n(o_bus_release_ack_n),
		.o_ack_oe(o_ack_oe)
	);
	pbh_mem u_mem (.i_clk(i_clk),
		.i_strobe_n(o_access_strobe_n | ~o_strobe_oe),
		.i_rw(o_read_write), .i_addr(o_addr_bus), .i_wdata(i_data_bus),
		.i_wait(wt), .o_ready_n(i_ready_n), .o_rdata(rdat), .o_rd_oe(rd_oe));
	// Keeper holds the last driven level when nobody drives
	assign i_data_bus = o_data_oe ? o_data_bus : rd_oe ? rdat : kp;
	always @(posedge i_clk) kp <= i_data_bus;
	always #5 i_clk = ~i_clk;
	// Hang guard, far above the well under one hundred cycles needed
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tick;
		@(posedge i_clk);
		#1;
	endtask
	// One access; request held until the edge that takes it
	task access(input logic r, input logic [23:0] a, input logic [31:0] d);
		int i;
		logic [3:0] pg;
		// Expected page held at four bits so the inverse is not widened
		pg = ~(4'h1 << a[23:22]);
		i_req_read = r;
		i_req_addr = a;
		i_req_wdata = d;
		i_req_valid = 1;
		i = 0;
		do begin
			@(posedge i_clk);
			i++;
		end while (o_req_ready !== 1 && i < 20);
		#1;
		i_req_valid = 0;
		chk(o_access_strobe_n, 0);
		chk(o_page_select_n, pg);
		chk(o_addr_bus, a);
		chk(o_read_write, r);
		chk(o_data_oe, !r);
		if (!r) chk(o_data_bus, d);
		for (i = 0; i < 20 && o_rsp_valid !== 1; i++) tick;
		chk(i, wt + 1);
		if (r) chk(o_rsp_rdata, d);
		if (!r) chk(o_data_bus, d);
	endtask
	task t_reset;
		i_nrst = 0;
		tick;
		tick;
		chk({o_addr_oe, o_data_oe, o_rw_oe, o_page_oe, o_strobe_oe,
			o_access_strobe_n, o_bus_release_ack_n, o_req_ready}, 8'h0e);
		i_nrst = 1;
		tick;
		chk(o_start_addr, 24'h00_0000);
		chk(o_req_ready, 1);
		$display("done reset");
	endtask
	// Every page, writes then reads back to back
	task t_pages;
		int p;
		for (p = 0; p < 8; p++)
			access(p >= 4, {p[1:0], 18'h0_0000, p[3:0] & 4'h3},
				32'h5a5a_0000 + p % 4);
		$display("done pages");
	endtask
	task t_wait;
		wt = 4'h3;
		access(0, 24'h40_0007, 32'h0f0f_1111);
		access(1, 24'h40_0007, 32'h0f0f_1111);
		wt = 4'h0;
		$display("done wait");
	endtask
	// Release requested in mid access
	task t_hold;
		int i;
		fork
			access(0, 24'h80_0005, 32'h1234_5678);
			begin tick; i_release_req_n = 0; end
		join
		for (i = 0; i < 4 && o_bus_release_ack_n !== 0; i++) tick;
		chk({o_bus_release_ack_n, o_addr_oe, o_data_oe, o_rw_oe,
			o_strobe_oe, o_req_ready}, 6'h00);
		tick;
		chk(o_req_ready, 0);
		i_release_req_n = 1;
		tick;
		chk(o_bus_release_ack_n, 0);
		tick;
		chk(o_bus_release_ack_n, 1);
		$display("done hold");
	endtask
	task t_ign;
		i_release_req_n = 0;
		tick;
		tick;
		i_ignore_release_req = 1;
		tick;
		chk(o_bus_release_ack_n, 1);
		access(1, 24'h80_0005, 32'h1234_5678);
		i_ignore_release_req = 0;
		i_release_req_n = 1;
		tick;
		tick;
		$display("done ignore");
	endtask
	task t_shz;
		i_shutdown_float_n = 0;
		#1;
		chk({o_addr_oe, o_data_oe, o_rw_oe, o_strobe_oe, o_page_oe,
			o_ack_oe}, 6'h00);
		tick;
		i_shutdown_float_n = 1;
		// reset again with float input high
		t_reset;
		$display("done shutdown");
	endtask
	initial begin
		t_reset;
		t_pages;
		t_wait;
		t_hold;
		t_ign;
		t_shz;
		give_verdict();
	end
endmodule // tb
`default_nettype wire
